// ==== rtl/eqca_access.sv ====
// Purpose: Register access logic for loading and reading back equalizer coefficients
// Assumes: Host holds a request until ack_o; requests are synchronous to clk_i
// Notes: Stretched accesses wait in BUS_HOLD until the access state is valid
`timescale 1ns/1ns
`default_nettype none
module eqca_access
   import eqca_pkg::*;
#(
   parameter int SAMPLE_W = 24,
   parameter int INIT_WAIT = INIT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   input wire eqca_req_s req_i,
   output logic ack_o,
   output logic [7:0] rdata_o,
   output logic stretch_o,
   input wire logic filter_power_down_i,
   input wire logic [SAMPLE_W-1:0] eq_in_i,
   output logic [SAMPLE_W-1:0] eq_in_o,
   output logic filter_run_o,
   output logic filter_skip_o,
   output logic audio_port_drive_strength_o,
   output logic ctrl_port_drive_strength_o,
   output logic playback_rate_converter_skip_o,
   output logic capture_rate_converter_skip_o,
   input wire logic [3:0] eng_idx_i,
   output logic [31:0] eng_coef_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Registers and state
   eqca_bus_e state;
   eqca_bus_e next_state;
   logic [7:0] start_ctrl;
   logic [7:0] conv_ctrl;
   logic [7:0] mute_ctrl;
   logic [7:0] access_ctrl;
   logic [7:0] load_b0;
   logic [7:0] load_b1;
   logic [7:0] load_b2;
   logic [31:0] hold_word;
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic readback_seen;
   logic init_done;
   logic [31:0] rd_word;
   logic [31:0] eng_word;

   ////////////////////////////////////////////////////////////////////////////
   // Access decode
   wire logic filter_run = start_ctrl[RUN_BIT];
   wire logic coef_load_enable = access_ctrl[LOAD_BIT];
   wire logic coef_readback_enable = access_ctrl[READBACK_BIT];
   wire logic filter_input_silence = mute_ctrl[SILENCE_BIT];
   wire logic access_ok = !filter_power_down_i && (coef_load_enable ^ coef_readback_enable);
   wire logic gated = (req_i.write && req_i.addr == ADDR_COEF_IN3)
                      || (!req_i.write && req_i.addr == ADDR_COEF_OUT0);
   wire logic enter_hold = state == BUS_IDLE && req_valid_i && gated && !access_ok;
   wire logic take = (state == BUS_IDLE && req_valid_i && !(gated && !access_ok))
                     || (state == BUS_HOLD && access_ok);
   wire logic do_wr = take && req_i.write;
   wire logic do_rd = take && !req_i.write;

   function automatic logic wr_at(input logic [15:0] a);
      return do_wr && req_i.addr == a;
   endfunction

   function automatic logic rd_at(input logic [15:0] a);
      return do_rd && req_i.addr == a;
   endfunction

   wire logic commit = do_wr && req_i.addr == ADDR_COEF_IN3 && coef_load_enable && !filter_run
                       && wr_ptr < NUM_COEF;
   wire logic latch = do_rd && req_i.addr == ADDR_COEF_OUT0 && coef_readback_enable && !filter_run
                      && rd_ptr < NUM_COEF;
   wire logic restore = do_wr && req_i.addr == ADDR_START_CTRL && !req_i.wdata[RUN_BIT]
                        && readback_seen;
   wire logic restart_ptrs = do_wr && req_i.addr == ADDR_ACCESS_CTRL;
   wire logic [31:0] commit_word = {req_i.wdata, load_b2, load_b1, load_b0};

   ////////////////////////////////////////////////////////////////////////////
   // Read data selection
   wire logic [7:0] status_byte = {7'h00, init_done};
   wire logic [7:0] next_rdata =
      (req_i.addr == ADDR_INIT_STATUS) ? status_byte :
      (req_i.addr == ADDR_START_CTRL) ? start_ctrl :
      (req_i.addr == ADDR_CONV_CTRL) ? conv_ctrl :
      (req_i.addr == ADDR_MUTE_CTRL) ? mute_ctrl :
      (req_i.addr == ADDR_ACCESS_CTRL) ? access_ctrl :
      (req_i.addr == ADDR_COEF_OUT0) ? (latch ? rd_word[7:0] : hold_word[7:0]) :
      (req_i.addr == ADDR_COEF_OUT1) ? hold_word[15:8] :
      (req_i.addr == ADDR_COEF_OUT2) ? hold_word[23:16] :
      (req_i.addr == ADDR_COEF_OUT3) ? hold_word[31:24] : 8'h00;

   assign next_state = take ? BUS_DONE :
                       enter_hold ? BUS_HOLD :
                       (state == BUS_DONE) ? BUS_IDLE : state;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= BUS_IDLE;
         ack_o <= 1'b0;
         stretch_o <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         state <= next_state;
         ack_o <= take;
         stretch_o <= enter_hold || (state == BUS_HOLD && !access_ok);
         if (do_rd) begin
            rdata_o <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_ctrl <= START_RESET;
         conv_ctrl <= CONV_RESET;
         mute_ctrl <= MUTE_RESET;
         access_ctrl <= ACCESS_RESET;
      end else begin
         if (wr_at(ADDR_START_CTRL)) begin
            start_ctrl <= {7'h00, req_i.wdata[RUN_BIT]};
         end
         if (wr_at(ADDR_CONV_CTRL)) begin
            conv_ctrl <= {3'h0, req_i.wdata[4:0]};
         end
         if (wr_at(ADDR_MUTE_CTRL)) begin
            mute_ctrl <= {7'h00, req_i.wdata[SILENCE_BIT]};
         end
         if (wr_at(ADDR_ACCESS_CTRL)) begin
            access_ctrl <= {6'h00, req_i.wdata[1:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Coefficient assembly, pointers and readback holding
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_b0 <= 8'h00;
         load_b1 <= 8'h00;
         load_b2 <= 8'h00;
         hold_word <= 32'h0000_0000;
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         readback_seen <= 1'b0;
      end else begin
         if (wr_at(ADDR_COEF_IN0)) begin
            load_b0 <= req_i.wdata;
         end
         if (wr_at(ADDR_COEF_IN1)) begin
            load_b1 <= req_i.wdata;
         end
         if (wr_at(ADDR_COEF_IN2)) begin
            load_b2 <= req_i.wdata;
         end
         if (restart_ptrs) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
         end else begin
            if (commit) begin
               wr_ptr <= wr_ptr + 4'h1;
            end
            if (latch) begin
               rd_ptr <= rd_ptr + 4'h1;
            end
         end
         if (latch) begin
            hold_word <= rd_word;
         end
         if (restore || commit) begin
            readback_seen <= 1'b0;
         end else if (latch) begin
            readback_seen <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs toward the filter datapath and the serial port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eq_in_o <= '0;
         filter_run_o <= START_RESET[RUN_BIT];
         filter_skip_o <= 1'b0;
         audio_port_drive_strength_o <= 1'b0;
         ctrl_port_drive_strength_o <= 1'b0;
         playback_rate_converter_skip_o <= 1'b0;
         capture_rate_converter_skip_o <= 1'b0;
         eng_coef_o <= 32'h0000_0000;
      end else begin
         eq_in_o <= filter_input_silence ? '0 : eq_in_i;
         filter_run_o <= filter_run;
         filter_skip_o <= conv_ctrl[FILTER_SKIP_BIT];
         audio_port_drive_strength_o <= conv_ctrl[PORT_DRIVE_BIT];
         ctrl_port_drive_strength_o <= conv_ctrl[CTRL_DRIVE_BIT];
         playback_rate_converter_skip_o <= conv_ctrl[PLAY_SKIP_BIT];
         capture_rate_converter_skip_o <= conv_ctrl[CAP_SKIP_BIT];
         eng_coef_o <= eng_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   eqca_coef_store eqca_coef_store_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(commit),
      .wr_idx_i(wr_ptr),
      .wr_data_i(commit_word),
      .restore_i(restore),
      .rd_idx_i(rd_ptr),
      .rd_data_o(rd_word),
      .eng_idx_i(eng_idx_i),
      .eng_data_o(eng_word)
   );

   eqca_init_timer #(
      .CYCLES(INIT_WAIT)
   ) eqca_init_timer_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .power_down_i(filter_power_down_i),
      .done_o(init_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_stretch_in3: assert property (
      state == BUS_IDLE && req_valid_i && req_i.write && req_i.addr == ADDR_COEF_IN3
      && !access_ok |=> stretch_o && !ack_o)
      else $error("top input byte write not stretched in an invalid access state");
   a_stretch_out0: assert property (
      state == BUS_IDLE && req_valid_i && !req_i.write && req_i.addr == ADDR_COEF_OUT0
      && !access_ok |=> stretch_o && !ack_o)
      else $error("low output byte read not stretched in an invalid access state");
   a_hold_release: assert property (
      state == BUS_HOLD && access_ok |=> ack_o ##1 !stretch_o)
      else $error("held access not answered once valid");
   a_commit_ptr: assert property (
      commit && !restart_ptrs |=> wr_ptr == $past(wr_ptr) + 4'h1)
      else $error("slot pointer did not advance on commit");
   a_commit_gate: assert property (
      commit || latch |-> !filter_run && access_ok)
      else $error("coefficient moved while filter running");
   a_slot_bound: assert property (
      wr_ptr <= NUM_COEF && rd_ptr <= NUM_COEF)
      else $error("slot pointer beyond fifteen");
   a_order_restart: assert property (
      restart_ptrs |=> wr_ptr == 4'h0 && rd_ptr == 4'h0)
      else $error("pointers not restarted by access control write");
   a_latch_hold: assert property (
      latch |=> hold_word == $past(rd_word))
      else $error("holding register missed the next coefficient");
   a_silence_out: assert property (
      filter_input_silence |=> eq_in_o == '0)
      else $error("equalizer input not muted");
   a_restore_cause: assert property (
      restore |=> !readback_seen && !filter_run)
      else $error("restore did not follow a run clear");

   a_gated_wait: assert property (
      state == BUS_HOLD && !access_ok |=> stretch_o && !ack_o)
      else $error("held access answered before its access state was valid");
   a_ack_pulse: assert property (
      ack_o |=> !ack_o)
      else $error("answer pulse longer than one cycle");
   a_idle_quiet: assert property (
      state == BUS_IDLE && !req_valid_i |=> !ack_o && !stretch_o)
      else $error("answer or stretch without a request");
   a_readback_byte: assert property (
      latch |=> rdata_o == hold_word[7:0])
      else $error("low output byte not from the latched coefficient");
   a_upper_bytes: assert property (
      do_rd && req_i.addr == ADDR_COEF_OUT3 |=> rdata_o == $past(hold_word[31:24]))
      else $error("top output byte not from the held coefficient");
   a_rdata_stand: assert property (
      !do_rd |=> rdata_o == $past(rdata_o))
      else $error("read data changed without a read");
   a_ptr_hold_run: assert property (
      filter_run && !restart_ptrs |=> wr_ptr == $past(wr_ptr) && rd_ptr == $past(rd_ptr))
      else $error("slot pointer moved while filter running");
   a_latch_ptr: assert property (
      latch && !restart_ptrs |=> rd_ptr == $past(rd_ptr) + 4'h1)
      else $error("readback pointer did not advance on latch");
   a_store_byte: assert property (
      do_wr && req_i.addr == ADDR_COEF_IN0 |=> load_b0 == $past(req_i.wdata))
      else $error("low input byte not stored");
   a_silence_pass: assert property (
      !filter_input_silence |=> eq_in_o == $past(eq_in_i))
      else $error("equalizer input not passed while unmuted");
   a_run_follows: assert property (
      do_wr && req_i.addr == ADDR_START_CTRL |-> ##2 filter_run_o == $past(req_i.wdata[RUN_BIT], 2))
      else $error("run output did not follow the start control write");
   a_skip_follows: assert property (
      1'b1 |=> {filter_skip_o, ctrl_port_drive_strength_o, audio_port_drive_strength_o,
      playback_rate_converter_skip_o, capture_rate_converter_skip_o} == $past(conv_ctrl[4:0]))
      else $error("converter control outputs do not follow the register");
   a_init_gone: assert property (
      filter_power_down_i |=> status_byte == 8'h00)
      else $error("init flag readable as set while powered down");

   c_stretch_then_ack: cover property (enter_hold ##[1:20] take);
   c_full_load: cover property (commit && wr_ptr == 4'he);
   c_restore: cover property (restore);
   c_readback: cover property (latch ##[1:40] (do_rd && req_i.addr == ADDR_COEF_OUT3));
   c_read_held: cover property (enter_hold && !req_i.write);
endmodule
`default_nettype wire

// ==== rtl/eqca_pkg.sv ====
// Purpose: Shared constants and types for the equalizer coefficient access block
// Assumes: Byte-wide register port, 16-bit register addresses
// Notes: Coefficients are S1.30 two's complement words
package eqca_pkg;
   // Coefficient byte windows
   localparam logic [15:0] ADDR_COEF_IN0 = 16'h2401;
   localparam logic [15:0] ADDR_COEF_IN1 = 16'h2402;
   localparam logic [15:0] ADDR_COEF_IN2 = 16'h2403;
   localparam logic [15:0] ADDR_COEF_IN3 = 16'h2404;
   localparam logic [15:0] ADDR_COEF_OUT0 = 16'h2407;
   localparam logic [15:0] ADDR_COEF_OUT1 = 16'h2408;
   localparam logic [15:0] ADDR_COEF_OUT2 = 16'h2409;
   localparam logic [15:0] ADDR_COEF_OUT3 = 16'h240a;
   // Control and status registers
   localparam logic [15:0] ADDR_INIT_STATUS = 16'h2410;
   localparam logic [15:0] ADDR_START_CTRL = 16'h2411;
   localparam logic [15:0] ADDR_CONV_CTRL = 16'h2412;
   localparam logic [15:0] ADDR_MUTE_CTRL = 16'h2413;
   localparam logic [15:0] ADDR_ACCESS_CTRL = 16'h2414;
   // Field positions
   localparam int INIT_DONE_BIT = 0;
   localparam int RUN_BIT = 0;
   localparam int SILENCE_BIT = 0;
   localparam int READBACK_BIT = 0;
   localparam int LOAD_BIT = 1;
   localparam int CAP_SKIP_BIT = 0;
   localparam int PLAY_SKIP_BIT = 1;
   localparam int PORT_DRIVE_BIT = 2;
   localparam int CTRL_DRIVE_BIT = 3;
   localparam int FILTER_SKIP_BIT = 4;
   // Reset values
   localparam logic [7:0] START_RESET = 8'h01;
   localparam logic [7:0] CONV_RESET = 8'h00;
   localparam logic [7:0] MUTE_RESET = 8'h00;
   localparam logic [7:0] ACCESS_RESET = 8'h00;
   // Coefficient format
   localparam logic [3:0] NUM_COEF = 4'hf;
   localparam logic [31:0] COEF_UNITY = 32'h4000_0000;
   localparam logic [31:0] COEF_ZERO = 32'h0000_0000;
   // Initialization time after power-up of the filter
   localparam int CLK_PERIOD_NS = 4;
   localparam int INIT_TIME_NS = 100;
   localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } eqca_req_s;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_HOLD = 2'b01,
      BUS_DONE = 2'b10
   } eqca_bus_e;
endpackage

// ==== rtl/eqca_coef_store.sv ====
// Purpose: Fifteen-slot coefficient memory with pass-through restore
// Assumes: One write port, two combinational read ports
// Notes: Slot order is biquad 1..3, each b0, b1, a1, a2, b2
`timescale 1ns/1ns
`default_nettype none
module eqca_coef_store
   import eqca_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [31:0] wr_data_i,
   input wire logic restore_i,
   input wire logic [3:0] rd_idx_i,
   output logic [31:0] rd_data_o,
   input wire logic [3:0] eng_idx_i,
   output logic [31:0] eng_data_o
);
   logic [31:0] mem [0:14];

   // b0 sits at every fifth slot
   function automatic logic [31:0] unity_word(input int slot);
      return (slot % 5 == 0) ? COEF_UNITY : COEF_ZERO;
   endfunction

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 15; i++) begin
         if (rst_i || restore_i) begin
            mem[i] <= unity_word(i);
         end else if (wr_en_i && wr_idx_i == 4'(i)) begin
            mem[i] <= wr_data_i;
         end
      end
   end

   assign rd_data_o = (rd_idx_i < NUM_COEF) ? mem[rd_idx_i] : COEF_ZERO;
   assign eng_data_o = (eng_idx_i < NUM_COEF) ? mem[eng_idx_i] : COEF_ZERO;

   a_restore_unity: assert property (@(posedge clk_i) disable iff (rst_i)
      restore_i |=> mem[0] == COEF_UNITY && mem[1] == COEF_ZERO && mem[10] == COEF_UNITY)
      else $error("restore did not give pass-through coefficients");
endmodule
`default_nettype wire

// ==== rtl/eqca_init_timer.sv ====
// Purpose: Raises the initialization-complete flag after filter power-up
// Assumes: Power-down level synchronous to clk_i
// Notes: Flag drops at once on power-down
`timescale 1ns/1ns
`default_nettype none
module eqca_init_timer
   import eqca_pkg::*;
#(
   parameter int CYCLES = INIT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_down_i,
   output logic done_o
);
   logic [15:0] count;

   always_ff @(posedge clk_i) begin
      if (rst_i || power_down_i) begin
         count <= 16'h0000;
         done_o <= 1'b0;
      end else if (count < 16'(CYCLES)) begin
         count <= count + 16'h0001;
      end else begin
         done_o <= 1'b1;
      end
   end

   a_init_pdn_low: assert property (@(posedge clk_i) disable iff (rst_i)
      power_down_i |=> !done_o)
      else $error("init flag high while powered down");
endmodule
`default_nettype wire

// ==== verification/eqca_host_model.sv ====
// Purpose: Host processor model on the coefficient register bus
// Assumes: One request at a time, held until ack_i is sampled high
// Notes: Released request fields are inverted so stale values never match
`timescale 1ns/1ns
`default_nettype none
module eqca_host_model
   import eqca_pkg::*;
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [7:0] rdata_i,
   output logic req_valid_o,
   output eqca_req_s req_o
);
   int fails = 0;
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_o <= '{w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 400);
      if (ack_i !== 1'b1) fails++;
      q = rdata_i;
      req_valid_o <= 1'b0;
      req_o <= ~req_o;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask
   task automatic load_set(input logic [31:0] c [15]);
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         rd(ADDR_INIT_STATUS, q);
         n++;
      end while (q[INIT_DONE_BIT] !== 1'b1 && n < 50);
      if (q[INIT_DONE_BIT] !== 1'b1) fails++;
      wr(ADDR_START_CTRL, 8'h00);
      wr(ADDR_CONV_CTRL, 8'h00);
      wr(ADDR_MUTE_CTRL, 8'h01);
      wr(ADDR_ACCESS_CTRL, 8'h02);
      for (int i = 0; i < 15; i++) begin
         for (int b = 0; b < 4; b++) begin
            wr(ADDR_COEF_IN0 + 16'(b), c[i][8*b +: 8]);
         end
      end
      wr(ADDR_ACCESS_CTRL, 8'h00);
   endtask
   task automatic read_set(output logic [31:0] c [15]); // Direct bus only, no indirect method
      logic [7:0] q;
      wr(ADDR_ACCESS_CTRL, 8'h01);
      for (int i = 0; i < 15; i++) begin
         for (int b = 0; b < 4; b++) begin
            rd(ADDR_COEF_OUT0 + 16'(b), q);
            c[i][8*b +: 8] = q;
         end
      end
      wr(ADDR_ACCESS_CTRL, 8'h00);
   endtask
   task automatic finish_set();
      wr(ADDR_START_CTRL, 8'h01);
      wr(ADDR_MUTE_CTRL, 8'h00);
   endtask
endmodule
`default_nettype wire

// ==== verification/eqca_access_bench.sv ====
// Purpose: Self-checking bench for the coefficient access block
// Assumes: Host model drives the register bus, bench drives the rest
// Notes: Init wait shortened to 3 cycles
`timescale 1ns/1ns
`default_nettype none
module eqca_access_bench;
   import eqca_pkg::*;
   localparam int WAIT_CYC = 3;
   logic clk_i, rst_i, req_valid, ack, stretch, pd, run, skip, drv_a, drv_c, play, cap;
   eqca_req_s req;
   logic [7:0] rdata, q;
   logic [23:0] eq_in, eq_out;
   logic [3:0] eng_idx;
   logic [31:0] eng_coef;
   logic [31:0] coefs [15];
   logic [31:0] got [15];
   int mismatches = 0;
   int samples_checked = 0;

   eqca_access #(.INIT_WAIT(WAIT_CYC)) eqca_access_inst (.clk_i(clk_i), .rst_i(rst_i),
      .req_valid_i(req_valid), .req_i(req), .ack_o(ack), .rdata_o(rdata), .stretch_o(stretch),
      .filter_power_down_i(pd), .eq_in_i(eq_in), .eq_in_o(eq_out), .filter_run_o(run),
      .filter_skip_o(skip), .audio_port_drive_strength_o(drv_a), .ctrl_port_drive_strength_o(drv_c),
      .playback_rate_converter_skip_o(play), .capture_rate_converter_skip_o(cap),
      .eng_idx_i(eng_idx), .eng_coef_o(eng_coef));
   eqca_host_model eqca_host_model_inst (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata),
      .req_valid_o(req_valid), .req_o(req));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   function automatic logic [31:0] coef_val(input int i);
      return 32'(32'h9e37_79b9 * (i + 1));
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check_slots(input logic pass);
      for (int i = 0; i < 15; i++) begin
         @(posedge clk_i);
         eng_idx <= 4'(i);
         repeat (2) @(posedge clk_i);
         #1;
         check(eng_coef, pass ? ((i % 5 == 0) ? COEF_UNITY : COEF_ZERO) : coef_val(i));
      end
   endtask

   task automatic t_reset_regs();
      eqca_host_model_inst.rd(ADDR_INIT_STATUS, q);
      check(q, 8'h00);
      eqca_host_model_inst.rd(ADDR_START_CTRL, q);
      check(q, START_RESET);
      eqca_host_model_inst.rd(ADDR_MUTE_CTRL, q);
      check(q, MUTE_RESET);
      eqca_host_model_inst.rd(ADDR_ACCESS_CTRL, q);
      check(q, ACCESS_RESET);
      check_slots(1'b1);
      eqca_host_model_inst.wr(ADDR_CONV_CTRL, 8'hff);
      eqca_host_model_inst.rd(ADDR_CONV_CTRL, q);
      check(q, 8'h1f);
      check({skip, drv_c, drv_a, play, cap}, 32'h1f);
      eqca_host_model_inst.rd(16'h2400, q);
      check(q, 8'h00);
      @(posedge clk_i);
      pd <= 1'b0;
      repeat (WAIT_CYC + 4) @(posedge clk_i);
      eqca_host_model_inst.rd(ADDR_INIT_STATUS, q);
      check(q, 8'h01);
   endtask

   task automatic t_load_readback();
      for (int i = 0; i < 15; i++) coefs[i] = coef_val(i);
      eqca_host_model_inst.load_set(coefs);
      check(eq_out, 32'h0);
      check_slots(1'b0);
      eqca_host_model_inst.read_set(got);
      for (int i = 0; i < 15; i++) check(got[i], coef_val(i));
      eqca_host_model_inst.finish_set();
      repeat (2) @(posedge clk_i);
      #1;
      check(run, 1'b1);
      check(eq_out, 32'h12_3456);
   endtask

   task automatic t_restore();
      eqca_host_model_inst.wr(ADDR_START_CTRL, 8'h00);
      check_slots(1'b1);
      eqca_host_model_inst.wr(ADDR_START_CTRL, 8'h01);
      check_slots(1'b1);
      check(run, 1'b1);
   endtask

   task automatic t_stretch(input logic rd_side);
      eqca_host_model_inst.wr(ADDR_START_CTRL, 8'h00);
      eqca_host_model_inst.wr(ADDR_ACCESS_CTRL, rd_side ? 8'h01 : 8'h02);
      @(posedge clk_i);
      pd <= 1'b1;
      fork
         if (rd_side) eqca_host_model_inst.rd(ADDR_COEF_OUT0, q);
         else eqca_host_model_inst.wr(ADDR_COEF_IN3, 8'h7f);
         begin
            repeat (6) @(posedge clk_i);
            #1;
            check(stretch, 1'b1);
            check(ack, 1'b0);
            @(posedge clk_i);
            pd <= 1'b0;
         end
      join
      #1;
      check(stretch, 1'b0);
   endtask

   task automatic t_mid_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(run, 1'b1);
      check(stretch, 1'b0);
      check(eq_out, 32'h0);
      check_slots(1'b1);
   endtask

   task automatic report_and_stop();
      mismatches += eqca_host_model_inst.fails;
      $display("TB: %0d mismatches, %0d checks", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      rst_i = 1'b1;
      pd = 1'b1;
      eq_in = 24'h12_3456;
      eng_idx = 4'h0;
      fork
         begin
            repeat (20) @(posedge clk_i);
            rst_i <= 1'b0;
            #1;
            check(run, 1'b1);
            t_reset_regs();
            t_load_readback();
            t_restore();
            t_stretch(1'b0);
            t_stretch(1'b1);
            check(q, coef_val(14) & 32'hff);
            t_mid_reset();
            report_and_stop();
         end
         begin
            #80000;
            mismatches++;
            report_and_stop();
         end
      join
   end
endmodule
`default_nettype wire
